// *** core/pwc_pin_cfg.sv ***
// pin, chip variant and watchdog configuration register bank
// assumes a synchronous register port from the serial bus decoder,
// synchronous pin input and factory straps steady around reset
//
// Functional notes
// - direction 0 drives the pin, 1 makes it input; input after reset
// - output drive open-drain when drive type 0, push-pull when 1
// - output value 0 drives low; 1 drives high or releases (open-drain)
// - in input configuration output value and drive type are ignored
// - input value bit shows the sensed pin level, the debounced level when filter enable is set
// - filter enable applies a 30 ms debounce to the pin input
// - alternate select hands pin to sequencer, active high; factory reset
// - read-only 5-bit chip variant code naming the factory set
// - feed reloads watchdog; period 16 to 128 s doubling, 0b11 at reset
// - expiry powers off when action is 0, power reset when 1
// - enabled watchdog runs and expires unless fed; disabled stops
// - lock bit set lets enable be set but never cleared
`timescale 1ns/1ps
`include "pwc_regs.svh"

module pwc_pin_cfg
    import pwc_pkg::*;
#(
    parameter int TICK_CYCLES = `PWC_TICK_CYCLES,
    parameter int DEB_TICKS = `PWC_DEB_TICKS,
    parameter int WD_BASE_TICKS = `PWC_WD_BASE_TICKS
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // factory straps
    input wire logic otp_alt_in,
    input wire logic [4:0] otp_variant_in,
    input wire logic otp_wd_en_in,
    input wire logic otp_wd_lock_in,
    // general_pin_one
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    input wire logic seq_level_in,
    // watchdog actions
    output logic wd_power_off_out,
    output logic wd_power_reset_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int DW = $clog2(DEB_TICKS + 1);

    typedef struct packed
    {
        logic [1:0] p_rsvd;
        logic alt;
        logic filt_en;
        logic out_val;
        logic drv;
        logic dir;
        logic [1:0] w_rsvd;
        logic [1:0] per;
        logic act;
        logic feed;
        logic en;
        logic lock;
        logic [4:0] variant;
        logic loaded;
        logic filt_q;
        logic [DW-1:0] deb_cnt;
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic [7:0] rdata;
        logic pin_o;
        logic pin_oe;
        logic pwr_off;
        logic pwr_rst;
    } pwc_bank_t;

    pwc_bank_t r, nxt;
    pwc_wd_if wd_bus();

    logic wr_pin;
    logic wr_wd;

    assign wr_pin = reg_wr_in && reg_addr_in == `PWC_OFS_PIN1_CONFIG;
    assign wr_wd = reg_wr_in && reg_addr_in == `PWC_OFS_WD_CONFIG;

    assign wd_bus.tick = r.tick;
    assign wd_bus.enable = r.en;
    assign wd_bus.period = r.per;
    assign wd_bus.feed = r.feed;

    pwc_watchdog #(
        .BASE_TICKS(WD_BASE_TICKS)
    ) u_wd (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .wd(wd_bus.timer)
    );

    always_comb
    begin
        nxt = r;
        // ============================================================
        // millisecond tick shared by debounce and watchdog
        nxt.tick = 1'b0;
        if (r.tick_cnt == TW'(TICK_CYCLES - 1))
        begin
            nxt.tick_cnt = '0;
            nxt.tick = 1'b1;
        end
        else
        begin
            nxt.tick_cnt = r.tick_cnt + TW'(1);
        end

        // ============================================================
        // straps are caught one cycle after reset release
        if (!r.loaded)
        begin
            nxt.loaded = 1'b1;
            // factory reset value of alternate select
            nxt.alt = otp_alt_in;
            // variant code latched from the factory set
            nxt.variant = otp_variant_in;
            nxt.en = otp_wd_en_in;
            nxt.lock = otp_wd_lock_in;
        end

        // ============================================================
        // register writes
        if (wr_pin)
        begin
            nxt.p_rsvd = reg_wdata_in[`PWC_PIN_RSVD_LSB +: 2];
            nxt.alt = reg_wdata_in[`PWC_PIN_ALT_BIT];
            nxt.filt_en = reg_wdata_in[`PWC_PIN_FILT_BIT];
            nxt.out_val = reg_wdata_in[`PWC_PIN_DO_BIT];
            nxt.drv = reg_wdata_in[`PWC_PIN_DRV_BIT];
            nxt.dir = reg_wdata_in[`PWC_PIN_DIR_BIT];
        end
        // feed lasts one cycle, consumed by the timer
        nxt.feed = 1'b0;
        if (wr_wd)
        begin
            nxt.w_rsvd = reg_wdata_in[`PWC_WD_RSVD_LSB +: 2];
            nxt.per = reg_wdata_in[`PWC_WD_PER_LSB +: 2];
            nxt.act = reg_wdata_in[`PWC_WD_ACT_BIT];
            nxt.feed = reg_wdata_in[`PWC_WD_FEED_BIT];
            nxt.en = reg_wdata_in[`PWC_WD_EN_BIT] | (r.lock & r.en);
        end

        // ============================================================
        // input debounce
        // bypass when clear, 30 ms steady level when set
        if (!r.filt_en)
        begin
            nxt.filt_q = pin_in;
            nxt.deb_cnt = '0;
        end
        else if (pin_in == r.filt_q)
        begin
            nxt.deb_cnt = '0;
        end
        else if (r.tick)
        begin
            if (r.deb_cnt >= DW'(DEB_TICKS - 1))
            begin
                nxt.filt_q = pin_in;
                nxt.deb_cnt = '0;
            end
            else
            begin
                nxt.deb_cnt = r.deb_cnt + DW'(1);
            end
        end

        // ============================================================
        // pin drive
        if (r.alt)
        begin
            // sequencer owns the pin, active-high push-pull
            nxt.pin_oe = 1'b1;
            nxt.pin_o = seq_level_in;
        end
        else if (r.dir)
        begin
            // input: value and drive type have no effect
            nxt.pin_oe = 1'b0;
            nxt.pin_o = 1'b0;
        end
        else
        begin
            nxt.pin_oe = r.drv | ~r.out_val;
            nxt.pin_o = r.out_val;
        end

        // ============================================================
        // watchdog action
        // expiry action chooses power-off or power reset
        nxt.pwr_off = wd_bus.expire & ~r.act;
        nxt.pwr_rst = wd_bus.expire & r.act;

        // ============================================================
        // read data, reserved bits of the id register read zero
        nxt.rdata = r.rdata;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                `PWC_OFS_PIN1_CONFIG:
                begin
                    nxt.rdata = {r.p_rsvd, r.alt, r.filt_en, r.out_val,
                                 r.drv, r.filt_q, r.dir};
                end
                `PWC_OFS_CHIP_VARIANT_ID:
                begin
                    nxt.rdata = {3'h0, r.variant};
                end
                `PWC_OFS_WD_CONFIG:
                begin
                    nxt.rdata = {r.w_rsvd, r.per, r.act, r.feed, r.en,
                                 r.lock};
                end
                default:
                begin
                    nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            r <= '0;
            r.dir <= `PWC_RST_DIR;
            r.per <= `PWC_RST_WD_PER;
        end
        else
        begin
            r <= nxt;
        end
    end

    assign reg_rdata_out = r.rdata;
    assign pin_out = r.pin_o;
    assign pin_oe_out = r.pin_oe;
    assign wd_power_off_out = r.pwr_off;
    assign wd_power_reset_out = r.pwr_rst;
endmodule

// *** core/pwc_pkg.sv ***
// types shared by the pin and watchdog configuration block
// assumes pwc_regs.svh supplies the numeric constants
package pwc_pkg;

    // ============================================================
    // watchdog states, gray along idle -> run -> fire
    typedef enum logic [1:0]
    {
        PWC_WD_IDLE = 2'h0,
        PWC_WD_RUN = 2'h1,
        PWC_WD_FIRE = 2'h3
    } pwc_wd_state_t;

endpackage

// *** core/pwc_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

// ============================================================
// offsets
`define PWC_OFS_PIN1_CONFIG 8'h09
`define PWC_OFS_CHIP_VARIANT_ID 8'h10
`define PWC_OFS_WD_CONFIG 8'h17

// ============================================================
// pin1_config fields
`define PWC_PIN_DIR_BIT 0
`define PWC_PIN_DI_BIT 1
`define PWC_PIN_DRV_BIT 2
`define PWC_PIN_DO_BIT 3
`define PWC_PIN_FILT_BIT 4
`define PWC_PIN_ALT_BIT 5
`define PWC_PIN_RSVD_LSB 6

// ============================================================
// wd_config fields
`define PWC_WD_LOCK_BIT 0
`define PWC_WD_EN_BIT 1
`define PWC_WD_FEED_BIT 2
`define PWC_WD_ACT_BIT 3
`define PWC_WD_PER_LSB 4
`define PWC_WD_RSVD_LSB 6

// ============================================================
// reset values
`define PWC_RST_DIR 1'b1
`define PWC_RST_WD_PER 2'h3

// ============================================================
// timing
`define PWC_CLK_MHZ 100
`define PWC_TICK_US 1000
`define PWC_DEB_MS 30
`define PWC_WD_BASE_S 16
`define PWC_TICK_CYCLES (`PWC_TICK_US * `PWC_CLK_MHZ)
`define PWC_DEB_TICKS (`PWC_DEB_MS * 1000 / `PWC_TICK_US)
`define PWC_WD_BASE_TICKS (`PWC_WD_BASE_S * 1000000 / `PWC_TICK_US)

`endif

// *** core/pwc_watchdog.sv ***
// watchdog down-counter in millisecond ticks
// assumes tick is a one-cycle enable from the bank's divider
`timescale 1ns/1ps
`include "pwc_regs.svh"

module pwc_watchdog
    import pwc_pkg::*;
#(
    parameter int BASE_TICKS = `PWC_WD_BASE_TICKS
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // control side
    pwc_wd_if.timer wd
);
    localparam int CW = $clog2(BASE_TICKS * 8 + 1);

    typedef struct packed
    {
        pwc_wd_state_t st;
        logic [CW-1:0] cnt;
        logic [1:0] per;
        logic expire;
    } pwc_wd_s_t;

    pwc_wd_s_t r, nxt;
    logic [CW-1:0] load_val;

    assign load_val = CW'(BASE_TICKS) << wd.period;
    assign wd.expire = r.expire;

    always_comb
    begin
        nxt = r;
        nxt.expire = 1'b0;
        nxt.per = wd.period;
        unique case (r.st)
            PWC_WD_IDLE:
            begin
                nxt.cnt = load_val;
                if (wd.enable)
                begin
                    nxt.st = PWC_WD_RUN;
                end
            end
            PWC_WD_RUN:
            begin
                if (!wd.enable)
                begin
                    nxt.st = PWC_WD_IDLE;
                end
                // feed reloads period; period change also reloads
                else if (wd.feed || wd.period != r.per)
                begin
                    nxt.cnt = load_val;
                end
                else if (wd.tick)
                begin
                    if (r.cnt <= CW'(1))
                    begin
                        nxt.st = PWC_WD_FIRE;
                    end
                    else
                    begin
                        nxt.cnt = r.cnt - CW'(1);
                    end
                end
            end
            PWC_WD_FIRE:
            begin
                nxt.expire = 1'b1;
                nxt.cnt = load_val;
                nxt.st = PWC_WD_RUN;
            end
            default:
            begin
                nxt.st = PWC_WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            r <= '{st: PWC_WD_IDLE, cnt: '0, per: `PWC_RST_WD_PER,
                   expire: 1'b0};
        end
        else
        begin
            r <= nxt;
        end
    end
endmodule

// *** core/pwc_wd_if.sv ***
// carrier between the register bank and the watchdog timer
// assumes both ends share sys_clk_in
`timescale 1ns/1ps

interface pwc_wd_if;
    logic tick;
    logic enable;
    logic [1:0] period;
    logic feed;
    logic expire;

    modport ctrl
    (
        output tick,
        output enable,
        output period,
        output feed,
        input expire
    );

    modport timer
    (
        input tick,
        input enable,
        input period,
        input feed,
        output expire
    );
endinterface

// *** sim/pwc_pin_cfg_sva.sv ***
// assertions on the ports of the pin and watchdog register bank
// assumes factory straps stay steady outside reset
`timescale 1ns/1ps
`include "pwc_regs.svh"

module pwc_pin_cfg_sva
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [4:0] otp_variant_in,
    // pin and watchdog
    input wire logic pin_out,
    input wire logic pin_oe_out,
    input wire logic wd_power_off_out,
    input wire logic wd_power_reset_out
);
    logic [7:0] wd1_r;
    logic [7:0] wd2_r;
    logic mapped;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // write data two edges back lines up with the pin flops
    always_ff @(posedge sys_clk_in)
    begin
        wd1_r <= reg_wdata_in;
        wd2_r <= wd1_r;
    end
    assign mapped = reg_addr_in inside {`PWC_OFS_PIN1_CONFIG,
        `PWC_OFS_CHIP_VARIANT_ID, `PWC_OFS_WD_CONFIG};

    sequence s_wr_pin;
        reg_wr_in && reg_addr_in == `PWC_OFS_PIN1_CONFIG;
    endsequence
    sequence s_pulse;
        wd_power_off_out || wd_power_reset_out;
    endsequence

    property p_rst_quiet;
        $fell(sys_rst_in) |-> !pin_oe_out && reg_rdata_out == 8'h00;
    endproperty
    property p_unmapped;
        reg_rd_in && !mapped |=> reg_rdata_out == 8'h00;
    endproperty
    property p_variant;
        reg_rd_in && reg_addr_in == `PWC_OFS_CHIP_VARIANT_ID
            |=> reg_rdata_out == {3'h0, $past(otp_variant_in)};
    endproperty
    property p_rd_hold;
        !reg_rd_in |=> $stable(reg_rdata_out);
    endproperty
    property p_out_drive;
        s_wr_pin ##0 (!reg_wdata_in[5] && !reg_wdata_in[0]) |-> ##2
            pin_oe_out == (wd2_r[2] || !wd2_r[3]) &&
            (!pin_oe_out || pin_out == wd2_r[3]);
    endproperty
    property p_in_off;
        s_wr_pin ##0 (!reg_wdata_in[5] && reg_wdata_in[0])
            |-> ##2 !pin_oe_out;
    endproperty
    property p_alt_on;
        s_wr_pin ##0 reg_wdata_in[5] |-> ##2 pin_oe_out;
    endproperty
    property p_pulse_one;
        s_pulse |=> !wd_power_off_out && !wd_power_reset_out;
    endproperty
    property p_one_action;
        !(wd_power_off_out && wd_power_reset_out);
    endproperty

    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_variant: assert property (p_variant)
        else $error("variant code read wrong");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    a_out_drive: assert property (p_out_drive)
        else $error("output drive wrong");
    a_in_off: assert property (p_in_off)
        else $error("input pin driven");
    a_alt_on: assert property (p_alt_on)
        else $error("alternate pin not driven");
    a_pulse_one: assert property (p_pulse_one)
        else $error("expiry pulse longer than one cycle");
    a_one_action: assert property (p_one_action)
        else $error("both expiry actions at once");
endmodule

bind pwc_pin_cfg pwc_pin_cfg_sva i_sva
(
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .otp_variant_in(otp_variant_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .wd_power_off_out(wd_power_off_out),
    .wd_power_reset_out(wd_power_reset_out)
);

// *** sim/pwc_pin_model.sv ***
// pin partner: external pull-up plus an optional outside driver
// assumes the bench never lets the outside driver fight the design
`timescale 1ns/1ps

module pwc_pin_model
(
    // design side
    input wire logic pin_out_in,
    input wire logic pin_oe_in,
    // outside driver
    input wire logic ext_en_in,
    input wire logic ext_lvl_in,
    // sensed level
    output logic pin_lvl_out
);
    assign pin_lvl_out = pin_oe_in ? pin_out_in :
        (ext_en_in ? ext_lvl_in : 1'b1);
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the pin and watchdog register bank
// assumes design, checker and pin model are compiled first
`timescale 1ns/1ps
`include "pwc_regs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", n, e, g); \
    end end

module tb_top;
    localparam logic [4:0] variant_code = 5'h15; // arbitrary value
    localparam logic [7:0] pin_cfg [5] = '{8'h08, 8'h0C, 8'h00, 8'h01,
        8'h0D};
    localparam logic [4:0] oe_exp = 5'b00110;
    localparam logic [4:0] lv_exp = 5'b11011;
    logic sys_clk_in = 0, sys_rst_in = 1, wr = 0, rd = 0, alt = 0;
    logic en = 0, lock = 0, seq = 0, ext_en = 0, ext_lvl = 0;
    logic oe, po, lvl, off, prst;
    logic [7:0] addr = 0, wdat = 0, rdat, d;
    int num_errors = 0, compares = 0, cycles = 0, off_n = 0, rr_n = 0;

    pwc_pin_cfg #(.TICK_CYCLES(4), .DEB_TICKS(3), .WD_BASE_TICKS(5)) i_dut
    (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdat), .reg_rdata_out(rdat), .otp_alt_in(alt),
        .otp_variant_in(variant_code), .otp_wd_en_in(en),
        .otp_wd_lock_in(lock), .pin_in(lvl), .pin_out(po),
        .pin_oe_out(oe), .seq_level_in(seq),
        .wd_power_off_out(off), .wd_power_reset_out(prst)
    );
    pwc_pin_model i_pin
    (
        .pin_out_in(po), .pin_oe_in(oe), .ext_en_in(ext_en),
        .ext_lvl_in(ext_lvl), .pin_lvl_out(lvl)
    );

    // ==========================================================
    // clock, pulse counters and hang guard
    initial
    begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // pulses are counted at the falling edge, clear of the launching edge
    always @(negedge sys_clk_in)
    begin
        cycles++;
        off_n += (off === 1'b1);
        rr_n += (prst === 1'b1);
        if (cycles == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task stop_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // bus tasks, entered at a falling edge
    task idle(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task wrb(input logic [7:0] a, input logic [7:0] v);
        addr = a;
        wdat = v;
        wr = 1;
        idle(1);
        wr = 0;
        idle(1);
    endtask
    task rdb(input logic [7:0] a);
        addr = a;
        rd = 1;
        idle(1);
        rd = 0;
        idle(1);
        d = rdat;
    endtask
    task do_reset(input logic l);
        lock = l;
        en = l;
        sys_rst_in = 1;
        idle(10);
        sys_rst_in = 0;
        idle(2);
    endtask

    // ==========================================================
    // scenarios
    task t_regs;
        rdb(`PWC_OFS_PIN1_CONFIG);
        `CHK("pin1_rst", 8'h03, d)
        rdb(`PWC_OFS_WD_CONFIG);
        `CHK("wd_rst", 8'h30, d)
        wrb(`PWC_OFS_CHIP_VARIANT_ID, 8'hFF);
        rdb(`PWC_OFS_CHIP_VARIANT_ID);
        `CHK("variant", {3'h0, variant_code}, d)
        rdb(8'h20);
        `CHK("unmapped", 8'h00, d)
    endtask
    task t_pin;
        for (int i = 0; i < 5; i++)
        begin
            wrb(`PWC_OFS_PIN1_CONFIG, pin_cfg[i]);
            // new pin level reaches the input flop one cycle after the pin
            idle(2);
            `CHK("pin_oe", oe_exp[i], oe)
            `CHK("pin_lvl", lv_exp[i], lvl)
            rdb(`PWC_OFS_PIN1_CONFIG);
            `CHK("pin1_rb", pin_cfg[i] | {6'h00, lv_exp[i], 1'b0}, d)
        end
    endtask
    task t_alt;
        seq = 1;
        wrb(`PWC_OFS_PIN1_CONFIG, 8'h20);
        idle(1);
        `CHK("alt_hi", 1'b1, lvl)
        seq = 0;
        idle(2);
        `CHK("alt_lo", 1'b0, lvl)
        wrb(`PWC_OFS_PIN1_CONFIG, 8'h01);
        idle(1);
        `CHK("alt_off", 1'b0, oe)
    endtask
    task t_filter;
        ext_en = 1;
        idle(16);
        rdb(`PWC_OFS_PIN1_CONFIG);
        `CHK("di_raw", 1'b0, d[1])
        wrb(`PWC_OFS_PIN1_CONFIG, 8'h11);
        ext_lvl = 1;
        idle(2);
        rdb(`PWC_OFS_PIN1_CONFIG);
        `CHK("di_held", 1'b0, d[1])
        idle(20);
        rdb(`PWC_OFS_PIN1_CONFIG);
        `CHK("di_filt", 1'b1, d[1])
        ext_en = 0;
        wrb(`PWC_OFS_PIN1_CONFIG, 8'h01);
    endtask
    task expire(input logic [7:0] c, input int lo, hi, input logic act);
        int k, o, n;
        wrb(`PWC_OFS_WD_CONFIG, c);
        k = off_n + rr_n;
        o = off_n;
        n = 0;
        while (off_n + rr_n == k && n < 100)
        begin
            idle(1);
            n++;
        end
        `CHK("wd_time", 1'b1, n >= lo && n <= hi)
        `CHK("wd_action", act, off_n == o)
    endtask
    task t_wd;
        int k;
        expire(8'h02, 12, 30, 1'b0);
        expire(8'h1A, 34, 54, 1'b1);
        expire(8'h22, 74, 94, 1'b0);
        k = off_n + rr_n;
        repeat (10)
        begin
            wrb(`PWC_OFS_WD_CONFIG, 8'h06);
            idle(4);
        end
        `CHK("wd_fed", k, off_n + rr_n)
        rdb(`PWC_OFS_WD_CONFIG);
        `CHK("feed_clr", 8'h02, d)
        wrb(`PWC_OFS_WD_CONFIG, 8'h00);
        k = off_n + rr_n;
        idle(60);
        `CHK("wd_stop", k, off_n + rr_n)
        rdb(`PWC_OFS_WD_CONFIG);
        `CHK("en_clr", 8'h00, d)
    endtask
    task t_lock;
        alt = 1;
        seq = 1;
        do_reset(1'b1);
        rdb(`PWC_OFS_PIN1_CONFIG);
        `CHK("alt_rst", 8'h23, d)
        rdb(`PWC_OFS_WD_CONFIG);
        `CHK("lock_rst", 8'h33, d)
        wrb(`PWC_OFS_WD_CONFIG, 8'h30);
        rdb(`PWC_OFS_WD_CONFIG);
        `CHK("lock_hold", 8'h33, d)
    endtask

    initial
    begin
        do_reset(1'b0);
        t_regs();
        t_pin();
        t_alt();
        t_filter();
        t_wd();
        t_lock();
        stop_test();
    end
endmodule
